//--- verif/core_memories.sv
`timescale 1ns/1ns
module core_memories
(
  input wire core_clk,
  input wire [12:0] prog_addr,
  output wire [13:0] prog_data,
  input wire [7:0] data_addr,
  output wire [7:0] data_rdata,
  input wire [7:0] data_waddr,
  input wire [7:0] data_wdata,
  input wire data_we
);
  reg [13:0] rom [0:511];
  reg [7:0] ram [0:255];

  // Whole word in the same cycle, no wait state
  assign prog_data = rom[prog_addr[8:0]];
  // Own data port, free during a fetch
  assign data_rdata = ram[data_addr];

  // Byte lands on the edge ending the write cycle
  always @(posedge core_clk)
    if (data_we)
      ram[data_waddr] <= data_wdata;
endmodule

//--- verif/risc_core_fetch_alu_tb_top.sv
`timescale 1ns/1ns
module risc_core_fetch_alu_tb_top;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg irq_req = 1'b0;
  wire [12:0] prog_addr;
  wire [13:0] prog_data;
  wire [7:0] data_addr;
  wire [7:0] data_rdata;
  wire [7:0] data_waddr;
  wire [7:0] data_wdata;
  wire data_we;
  wire irq_ack;
  wire [12:0] irq_return_addr;
  reg [47:0] rows [0:13];
  reg [47:0] r;
  integer bad_count = 0;
  integer total_checks = 0;
  integer wr_n = 0;
  integer i;

  // Core clock, 8 ns period
  always #4 core_clk = ~core_clk;

  risc_core_fetch_alu #(.PROG_WORDS(512)) i_dut
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .data_addr(data_addr),
    .data_rdata(data_rdata),
    .data_waddr(data_waddr),
    .data_wdata(data_wdata),
    .data_we(data_we),
    .irq_req(irq_req),
    .irq_ack(irq_ack),
    .irq_return_addr(irq_return_addr)
  );

  core_memories i_mem
  (
    .core_clk(core_clk),
    .prog_addr(prog_addr),
    .prog_data(prog_data),
    .data_addr(data_addr),
    .data_rdata(data_rdata),
    .data_waddr(data_waddr),
    .data_wdata(data_wdata),
    .data_we(data_we)
  );

  task complete_run;
  begin
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  task chk(input [12:0] got, input [12:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // A wait that ran out ends the run
  task hang;
  begin
    chk(13'h0000, 13'h1FFF);
    complete_run;
  end
  endtask

  // Each row writes its result, then the masked status
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      wr_n = 0;
    else if (data_we === 1'b1)
    begin
      r = rows[(wr_n / 2) % 14];
      chk(data_waddr, 13'h0020);
      if (wr_n % 2 == 0)
        chk(data_wdata, r[23:16]);
      else
        chk(data_wdata & r[7:0], r[15:8]);
      wr_n = wr_n + 1;
    end

  initial
  begin
    // Rows: op, accum, literal, result, status, status mask
    rows[0] = 48'h011234460007;
    rows[1] = 48'h018F71000707;
    rows[2] = 48'h020100FF0007;
    rows[3] = 48'h023535000707;
    rows[4] = 48'h03F03C300000;
    rows[5] = 48'h04F00FFF0000;
    rows[6] = 48'h05AAFF550000;
    rows[7] = 48'h085A00A50000;
    rows[8] = 48'h09FF00000000;
    rows[9] = 48'h0A0000FF0000;
    rows[10] = 48'h0B7700000000;
    rows[11] = 48'h0C1200210000;
    // Rotates through carry, carry in left set by the subtract in row 3, then by the rotate left in row 12
    rows[12] = 48'h068100030101;
    rows[13] = 48'h070200810001;
    for (i = 0; i < 512; i = i + 1)
      i_mem.rom[i] = 14'h0F00;
    // Jump over a store that must never run
    i_mem.rom[0] = 14'h2010;
    i_mem.rom[1] = 14'h0DA0;
    for (i = 0; i < 14; i = i + 1)
    begin
      i_mem.rom[16 + 5 * i] = {6'h10, rows[i][39:32]};
      i_mem.rom[17 + 5 * i] = {2'h1, rows[i][43:40], rows[i][31:24]};
      i_mem.rom[18 + 5 * i] = 14'h0DA0;
      i_mem.rom[19 + 5 * i] = 14'h0003;
      i_mem.rom[20 + 5 * i] = 14'h0DA0;
    end
    // Enable interrupts through the status register
    i_mem.rom[86] = 14'h1080;
    i_mem.rom[87] = 14'h0D83;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    for (i = 0; i < 600 && wr_n < 28; i = i + 1)
      @(negedge core_clk);
    if (wr_n < 28)
      hang;
    for (i = 0; i < 600 && prog_addr !== 13'h005A; i = i + 1)
      @(negedge core_clk);
    if (prog_addr !== 13'h005A)
      hang;
    irq_req = 1'b1;
    for (i = 0; i < 20 && irq_ack !== 1'b1; i = i + 1)
      @(negedge core_clk);
    if (irq_ack !== 1'b1)
      hang;
    chk(prog_addr, 13'h0004);
    chk(irq_return_addr, 13'h005A);
    irq_req = 1'b0;
    // Run on past the top of the 512-word space
    for (i = 0; i < 1000 && prog_addr !== 13'h01FF; i = i + 1)
      @(negedge core_clk);
    if (prog_addr !== 13'h01FF)
      hang;
    @(negedge core_clk);
    chk(prog_addr, 13'h0000);
    // Reset in mid-flow, then the whole table again
    reset_n = 1'b0;
    @(negedge core_clk);
    chk(prog_addr, 13'h0000);
    chk(data_we, 1'b0);
    chk(data_addr, 13'h0000);
    reset_n = 1'b1;
    for (i = 0; i < 600 && wr_n < 28; i = i + 1)
      @(negedge core_clk);
    if (wr_n < 28)
      hang;
    complete_run;
  end
endmodule

//--- verif/risc_core_sva.sv
`timescale 1ns/1ns
module risc_core_sva
#(
  parameter PROG_WORDS = 512
)
(
  input wire core_clk,
  input wire reset_n,
  input wire [12:0] prog_addr,
  input wire [7:0] data_waddr,
  input wire data_we,
  input wire irq_ack,
  input wire [12:0] irq_return_addr
);
  // One clock domain, so one default for all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Fetch address flow
  AST_WRAP: assert property (prog_addr < PROG_WORDS)
    else $error("fetch address above top");
  AST_RST_VEC: assert property
    ($rose(reset_n) |-> prog_addr == 13'h0000 ##1 prog_addr == 13'h0001)
    else $error("bad start after reset");
  // First slot is empty, so no write can come that early
  AST_RST_QUIET: assert property
    ($rose(reset_n) |-> !data_we ##1 !data_we)
    else $error("write too soon after reset");
  // Interrupt entry
  AST_IRQ_VEC: assert property
    (irq_ack |-> prog_addr == 13'h0004 ##1 prog_addr == 13'h0005)
    else $error("vector fetch wrong");
  AST_IRQ_RET: assert property
    (irq_ack |-> irq_return_addr == $past(prog_addr))
    else $error("return address wrong");
  AST_IRQ_HOLD: assert property
    (irq_ack |=> $stable(irq_return_addr))
    else $error("return address moved");
  AST_IRQ_ONCE: assert property (irq_ack |=> !irq_ack [*2])
    else $error("acknowledge not one pulse");
  // Core-held registers never leak onto the write port
  AST_SFR: assert property
    (data_we |-> !(data_waddr inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h0A}))
    else $error("core register written out");

  cover property (irq_ack);
  cover property (data_we && data_waddr == 8'h20);
  cover property ($rose(reset_n) ##2 1'b1);
endmodule

bind risc_core_fetch_alu risc_core_sva #(.PROG_WORDS(PROG_WORDS)) u_sva
(
  .core_clk(core_clk),
  .reset_n(reset_n),
  .prog_addr(prog_addr),
  .data_waddr(data_waddr),
  .data_we(data_we),
  .irq_ack(irq_ack),
  .irq_return_addr(irq_return_addr)
);

//--- verilog/core_alu.v
`timescale 1ns/1ns
`include "risc_core_defs.vh"

module core_alu
(
  input wire [3:0] op,
  input wire [7:0] acc,
  input wire [7:0] opnd,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output reg half_out,
  output reg upd_c,
  output reg upd_hc,
  output reg upd_z,
  output wire zero_out
);

  reg [8:0] sum9;
  reg [4:0] nib5;

  // Two's-complement datapath; subtract is opnd + ~acc + 1
  always @*
  begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    result = opnd;
    carry_out = carry_in;
    half_out = 1'b0;
    upd_c = 1'b0;
    upd_hc = 1'b0;
    upd_z = 1'b1;
    case (op)
      `OP_MOV: result = opnd;
      `OP_ADD:
      begin
        sum9 = {1'b0, opnd} + {1'b0, acc}; // [RULE_09] [RULE_10]
        nib5 = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
        result = sum9[7:0];
        carry_out = sum9[8];
        half_out = nib5[4];
        upd_c = 1'b1; // [RULE_14]
        upd_hc = 1'b1;
      end
      `OP_SUB:
      begin
        // Carry set means no borrow, likewise for the nibble
        sum9 = {1'b0, opnd} + {1'b0, ~acc} + 9'h001; // [RULE_15]
        nib5 = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result = sum9[7:0];
        carry_out = sum9[8];
        half_out = nib5[4];
        upd_c = 1'b1;
        upd_hc = 1'b1;
      end
      `OP_AND: result = acc & opnd;
      `OP_IOR: result = acc | opnd;
      `OP_XOR: result = acc ^ opnd;
      `OP_RLF:
      begin
        result = {opnd[6:0], carry_in}; // [RULE_09]
        carry_out = opnd[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      `OP_RRF:
      begin
        result = {carry_in, opnd[7:1]};
        carry_out = opnd[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      `OP_COM: result = ~opnd;
      `OP_INC: result = opnd + 8'h01;
      `OP_DEC: result = opnd - 8'h01;
      `OP_CLR: result = 8'h00;
      `OP_SWAP:
      begin
        result = {opnd[3:0], opnd[7:4]};
        upd_z = 1'b0;
      end
      `OP_MOVWF:
      begin
        result = acc;
        upd_z = 1'b0;
      end
      default: upd_z = 1'b0;
    endcase
  end

  assign zero_out = (result == 8'h00);

endmodule

//--- verilog/risc_core_defs.vh
`ifndef RISC_CORE_DEFS_VH
`define RISC_CORE_DEFS_VH

// Widths
`define INSN_W 14
`define PC_W 13
`define DATA_W 8
`define DADDR_W 8

// Vectors
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004

// Instruction groups, bits 13:12
`define GRP_FILE 2'h0
`define GRP_LIT 2'h1
`define GRP_JUMP 2'h2
`define GRP_RSVD 2'h3

// Operation codes, bits 11:8
`define OP_MOV 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_AND 4'h3
`define OP_IOR 4'h4
`define OP_XOR 4'h5
`define OP_RLF 4'h6
`define OP_RRF 4'h7
`define OP_COM 4'h8
`define OP_INC 4'h9
`define OP_DEC 4'hA
`define OP_CLR 4'hB
`define OP_SWAP 4'hC
`define OP_MOVWF 4'hD
`define OP_NOP 4'hF
// Literal-group codes from here up act on the accumulator alone
`define OP_SINGLE_FIRST 4'h6

// Core-held special function register addresses
`define SFR_INDIRECT 8'h00
`define SFR_PCL 8'h02
`define SFR_STATUS 8'h03
`define SFR_FSR 8'h04
`define SFR_PCHI 8'h0A

// Status bit positions and reset value
`define ST_CARRY 0
`define ST_HALF 1
`define ST_ZERO 2
`define ST_IRQ_EN 7
`define STATUS_RESET 8'h00

// Instruction loaded into the empty slot at reset
`define INSN_NOP 14'h0F00

`endif

//--- verilog/risc_core_fetch_alu.v
`timescale 1ns/1ns
`include "risc_core_defs.vh"

// Summary of operation
// RULE_01 - One 14-bit word fetched per cycle
// RULE_02 - Fetch of next overlaps current execution
// RULE_03 - Single-cycle instructions, branches take longer
// RULE_04 - Separate program and data buses
// RULE_05 - Thirteen-bit counter, 8K word space
// RULE_06 - Fetch address wraps inside implemented size
// RULE_07 - Reset starts fetching at address zero
// RULE_08 - Taken interrupt fetches from address four
// RULE_09 - Eight-bit ALU: add, subtract, shift, logic
// RULE_10 - Arithmetic is two's complement
// RULE_11 - Two operands: accumulator plus file or literal
// RULE_12 - Single operand: accumulator or one file
// RULE_13 - Accumulator is eight bits, not addressable
// RULE_14 - ALU updates carry, half carry, zero
// RULE_15 - Subtract flags act as borrow outputs
// RULE_16 - Core registers, counter too, in data space
// RULE_17 - Direct and indirect file addressing
// RULE_18 - Any operation on any file register
// RULE_19 - Counter change discards prefetched instruction
module risc_core_fetch_alu
#(
  parameter PROG_WORDS = 512
)
(
  input wire core_clk,
  input wire reset_n,
  output reg [12:0] prog_addr,
  input wire [13:0] prog_data,
  output reg [7:0] data_addr,
  input wire [7:0] data_rdata,
  output reg [7:0] data_waddr,
  output reg [7:0] data_wdata,
  output reg data_we,
  input wire irq_req,
  output reg irq_ack,
  output reg [12:0] irq_return_addr
);

  // Implemented program space mask; PROG_WORDS must be a power of two
  // Sized copy first, so the cut to 13 bits is deliberate
  localparam [31:0] PROG_LAST = PROG_WORDS - 1;
  localparam [12:0] PROG_MASK = PROG_LAST[12:0];

  // Pipeline slot and core-held registers
  reg [13:0] insn;
  reg slot_valid;
  reg [7:0] accum;
  reg [7:0] status;
  reg [7:0] fsr;
  reg [4:0] pc_upper;

  // Decode, operand and control nets
  wire [1:0] grp;
  wire [3:0] op;
  wire dst_file;
  wire [7:0] literal;
  reg [7:0] file_val;
  reg [7:0] alu_b;
  wire [7:0] alu_result;
  wire alu_c;
  wire alu_hc;
  wire alu_z;
  wire upd_c;
  wire upd_hc;
  wire upd_z;
  wire is_file;
  wire is_lit;
  wire is_jump;
  wire core_sfr;
  wire wr_file;
  wire wr_accum;
  wire flags_en;
  wire wr_pcl;
  wire jump;
  wire take_irq;
  wire [12:0] target;
  wire wr_status;
  wire wr_fsr;
  wire wr_pchi;
  wire flush;
  wire indirect_sel;
  wire [12:0] seq_pc;

  // Next-state values
  reg [7:0] next_status;
  reg [7:0] next_fsr;
  reg [12:0] next_pc;
  reg [7:0] next_data_addr;

  // Field split of the instruction now executing
  assign grp = insn[13:12];
  assign op = insn[11:8];
  assign dst_file = insn[7];
  assign literal = insn[7:0];
  assign is_file = slot_valid && (grp == `GRP_FILE);
  assign is_lit = slot_valid && (grp == `GRP_LIT);
  assign is_jump = slot_valid && (grp == `GRP_JUMP);

  // Registers kept in the core never go out on the data bus
  assign core_sfr = (data_addr == `SFR_INDIRECT) ||
                    (data_addr == `SFR_PCL) ||
                    (data_addr == `SFR_STATUS) ||
                    (data_addr == `SFR_FSR) ||
                    (data_addr == `SFR_PCHI);

  // File read: core registers, else memory with write forwarding
  always @*
  begin
    case (data_addr)
      `SFR_INDIRECT: file_val = 8'h00; // Indirect through itself
      `SFR_PCL: file_val = prog_addr[7:0]; // [RULE_16]
      `SFR_STATUS: file_val = status;
      `SFR_FSR: file_val = fsr;
      `SFR_PCHI: file_val = {3'h0, pc_upper};
      default:
      begin
        // Memory writes land a cycle late, so forward the pending one
        if (data_we && (data_waddr == data_addr))
          file_val = data_wdata;
        else
          file_val = data_rdata; // [RULE_04]
      end
    endcase
  end

  // Second operand: literal, file, or accumulator alone
  always @*
  begin
    if (is_lit && (op >= `OP_SINGLE_FIRST))
      alu_b = accum; // [RULE_12]
    else if (is_lit)
      alu_b = literal; // [RULE_11]
    else
      alu_b = file_val; // [RULE_11] [RULE_12] [RULE_18]
  end

  core_alu u_alu
  (
    .op(op),
    .acc(accum),
    .opnd(alu_b),
    .carry_in(status[`ST_CARRY]),
    .result(alu_result),
    .carry_out(alu_c),
    .half_out(alu_hc),
    .upd_c(upd_c),
    .upd_hc(upd_hc),
    .upd_z(upd_z),
    .zero_out(alu_z)
  );

  // Destination select; MOVWF in the file group always stores to the file
  assign wr_file = is_file && (op != `OP_NOP) &&
                   (dst_file || (op == `OP_MOVWF)); // [RULE_18]
  assign wr_accum = (is_file && !dst_file && (op != `OP_NOP) &&
                     (op != `OP_MOVWF)) ||
                    (is_lit && (op != `OP_NOP) && (op != `OP_MOVWF));
  assign flags_en = (is_file || is_lit) && (op != `OP_NOP);

  // Stores to core-held registers stay inside the core
  assign wr_status = wr_file && (data_addr == `SFR_STATUS); // [RULE_16]
  assign wr_fsr = wr_file && (data_addr == `SFR_FSR); // [RULE_16]
  assign wr_pchi = wr_file && (data_addr == `SFR_PCHI); // [RULE_16]

  // Program flow changes: jump or a store to the counter low byte
  assign wr_pcl = wr_file && (data_addr == `SFR_PCL); // [RULE_16]
  assign jump = is_jump || wr_pcl; // [RULE_03]
  assign target = is_jump ? {pc_upper[4:3], insn[10:0]} :
                            {pc_upper, alu_result};
  // Taking during a flow change would return to a discarded target,
  // so the take waits for the bubble that follows
  assign take_irq = irq_req && status[`ST_IRQ_EN] && !jump;
  // Either kind of flow change empties the slot behind it
  assign flush = jump || take_irq; // [RULE_19]
  // Plain step to the next word
  assign seq_pc = prog_addr + 13'h0001; // [RULE_05]

  // Status after this cycle; flag updates win over a plain store
  always @*
  begin
    next_status = status;
    if (wr_status)
      next_status = alu_result;
    if (flags_en && upd_c)
      next_status[`ST_CARRY] = alu_c; // [RULE_14] [RULE_15]
    if (flags_en && upd_hc)
      next_status[`ST_HALF] = alu_hc; // [RULE_14] [RULE_15]
    if (flags_en && upd_z)
      next_status[`ST_ZERO] = alu_z; // [RULE_14]
    if (take_irq)
      next_status[`ST_IRQ_EN] = 1'b0; // Blocks re-entry
  end

  // Pointer value seen by the instruction being fetched now
  always @*
  begin
    if (wr_fsr)
      next_fsr = alu_result;
    else
      next_fsr = fsr;
  end

  // Next fetch address, always kept inside the implemented space
  always @*
  begin
    // The vector lies inside every implemented size, so no mask
    if (take_irq)
      next_pc = `IRQ_VECTOR; // [RULE_08]
    else if (jump)
      next_pc = target & PROG_MASK; // [RULE_06]
    else
      next_pc = seq_pc & PROG_MASK; // [RULE_05] [RULE_06]
  end

  // Address field zero selects the pointer register instead
  assign indirect_sel = (prog_data[6:0] == 7'h00); // [RULE_17]

  // Decode the fetched word's file address ahead of execution
  always @*
  begin
    if (indirect_sel)
      next_data_addr = next_fsr; // [RULE_17]
    else
      next_data_addr = {1'b0, prog_data[6:0]}; // [RULE_17]
  end

  // Fetch stage and program counter
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_addr <= `RESET_VECTOR; // [RULE_07]
      insn <= `INSN_NOP;
      slot_valid <= 1'b0;
      data_addr <= 8'h00;
    end
    else
    begin
      prog_addr <= next_pc; // [RULE_02]
      insn <= prog_data; // [RULE_01]
      // A flow change flushes the word fetched behind it
      slot_valid <= !flush; // [RULE_19] [RULE_03]
      data_addr <= next_data_addr;
    end
  end

  // Interrupt outputs; the return address holds until the next take
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_ack <= 1'b0;
      irq_return_addr <= 13'h0000;
    end
    else
    begin
      irq_ack <= take_irq; // [RULE_08]
      if (take_irq)
        irq_return_addr <= prog_addr; // [RULE_19]
    end
  end

  // Execute stage: accumulator and core-held registers
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accum <= 8'h00;
      status <= `STATUS_RESET;
      fsr <= 8'h00;
      pc_upper <= 5'h00;
    end
    else
    begin
      if (wr_accum)
        accum <= alu_result; // [RULE_13]
      status <= next_status;
      fsr <= next_fsr;
      if (wr_pchi)
        pc_upper <= alu_result[4:0];
    end
  end

  // Data bus write, a cycle behind execute so the pins come from flops
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_we <= 1'b0;
      data_waddr <= 8'h00;
      data_wdata <= 8'h00;
    end
    else
    begin
      data_we <= wr_file && !core_sfr; // [RULE_04]
      data_waddr <= data_addr;
      data_wdata <= alu_result;
    end
  end

endmodule
